// >>> rtl/ov_response_consts.vh
// Purpose: Constants for the output over-voltage fault response controller
// Assumes: One system clock, byte-wide configuration register
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef OV_RESPONSE_CONSTS_VH
`define OV_RESPONSE_CONSTS_VH

// Command code of the response configuration byte
`define OVR_CFG_CODE        8'h41
// Command code of the delay-unit configuration
`define OVR_UNIT_CODE       8'hd2
// Field positions
`define OVR_RESP_HI         7
`define OVR_RESP_LO         6
`define OVR_RETRY_HI        5
`define OVR_RETRY_LO        3
`define OVR_DELAY_HI        2
`define OVR_DELAY_LO        0
// Response codes
`define OVR_RESP_IGNORE     2'h0
`define OVR_RESP_DELAYED    2'h1
`define OVR_RESP_SHUTDOWN   2'h2
`define OVR_RESP_HOLD       2'h3
// Retry codes
`define OVR_RETRY_NONE      3'h0
`define OVR_RETRY_FOREVER   3'h7
// Reset value of the configuration byte
`define OVR_CFG_RESET       8'h80
// Reset value of the delay unit, in clock cycles
`define OVR_UNIT_RESET      16'h0001
// Restart-pulse length in ns, and in cycles at 125 MHz
`define OVR_RESTART_NS      8
`define OVR_CLK_NS          8
`define OVR_RESTART_CYC     ((`OVR_RESTART_NS + `OVR_CLK_NS - 1) / `OVR_CLK_NS)

`endif

// >>> rtl/delay_timer.v
// Purpose: Counts 2^n delay units of a programmable cycle length
// Assumes: Start pulse restarts the count; unit of at least one cycle
// Notes:   Done is a one-cycle registered pulse
`timescale 1ns/100ps
module delay_timer #(
	parameter UNIT_W = 16
) (
	// Clock and reset
	input  wire              clk_sys,
	input  wire              rst_n,
	// Control
	input  wire              start,
	input  wire              cancel,
	input  wire [2:0]        exponent,
	input  wire [UNIT_W-1:0] unit_cycles,
	// Result
	output reg               busy,
	output reg               done
);
	reg  [UNIT_W-1:0] unit_cnt_q;
	reg  [7:0]        units_left_q;
	wire              unit_end;

	assign unit_end = (unit_cnt_q <= {{(UNIT_W-1){1'b0}}, 1'b1});

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			unit_cnt_q   <= {UNIT_W{1'b0}};
			units_left_q <= 8'h00;
			busy         <= 1'b0;
			done         <= 1'b0;
		end else begin
			done <= 1'b0;
			if (cancel) begin
				busy <= 1'b0;
			end else if (start) begin
				busy         <= 1'b1;
				unit_cnt_q   <= unit_cycles;
				units_left_q <= 8'h01 << exponent;
			end else if (busy) begin
				if (unit_end) begin
					unit_cnt_q <= unit_cycles;
					if (units_left_q == 8'h01) begin
						busy <= 1'b0;
						done <= 1'b1;
					end else begin
						units_left_q <= units_left_q - 8'h01;
					end
				end else begin
					unit_cnt_q <= unit_cnt_q - {{(UNIT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // delay_timer

// >>> rtl/ov_fault_response.v
// Purpose: Output over-voltage fault response controller with byte configuration
// Assumes: Fault level and on/off command arrive asynchronously; bus writes are same-clock
// Notes:   Bias-power loss is seen as rst_n
//
// Functional notes
// - Response 00 ignores the fault; output keeps regulating.
// - Response 01 runs for the delay, then applies retry setting if fault persists.
// - Response 10 disables output at once, then follows retry setting.
// - Response 11 holds output off while fault present, resumes when gone.
// - Latched fault clears by status clear, clear-all, reset, off-on, power loss.
// - Retry 000 makes no restart; output stays off until cleared.
// - Retry 001 to 011 allow one to three restarts, then latch off.
// - Restart attempts are spaced by delay count times delay unit.
// - Configuration is command 0x41, single-byte read and write.
// - Retry 100 to 110 allow four to six restarts, then latch off.
// - Delay field n selects 2^n units; unit from command 0xd2.
// - Continuous retry stops on off command, power loss or other fault.
`timescale 1ns/100ps
`include "ov_response_consts.vh"
module ov_fault_response #(
	parameter UNIT_W = 16
) (
	// Clock and reset
	input  wire              clk_sys,
	input  wire              rst_n,
	// Management bus byte access
	input  wire [7:0]        cmd_code,
	input  wire              wr_byte,
	input  wire [7:0]        wr_data,
	input  wire              rd_byte,
	output reg  [7:0]        rd_data,
	output reg               rd_valid,
	// Delay unit from the unit configuration
	input  wire [UNIT_W-1:0] unit_cycles,
	// Fault clearing
	input  wire              clear_status,
	input  wire              clear_faults,
	// Converter side
	input  wire              ov_fault_async,
	input  wire              output_on_async,
	input  wire              other_fault,
	output reg               output_enable,
	output reg               fault_latched,
	output reg               restart_pulse,
	output reg  [2:0]        attempt_count
);
	localparam ST_RUN     = 3'h0;
	localparam ST_DELAY   = 3'h1;
	localparam ST_WAIT    = 3'h2;
	localparam ST_HOLD    = 3'h3;
	localparam ST_LATCHED = 3'h4;

	reg  [7:0] cfg_q;
	reg  [2:0] state_q;
	reg        on_prev_q;
	reg        tmr_start_q;
	wire [1:0] pin_async;
	wire [1:0] pin_sync;
	wire       fault;
	wire       on_now;
	wire       on_rise;
	wire       off_cmd;
	wire       any_clear;
	wire       cfg_hit;
	wire [1:0] resp;
	wire [2:0] retries;
	wire [2:0] delay_exp;
	wire       tmr_cancel;
	wire       tmr_busy;
	wire       tmr_done;
	wire       may_retry;
	genvar     gi;

	assign pin_async  = {output_on_async, ov_fault_async};
	assign fault      = pin_sync[0];
	assign on_now     = pin_sync[1];
	assign on_rise    = on_now & ~on_prev_q;
	assign off_cmd    = on_prev_q & ~on_now;
	assign any_clear  = clear_status | clear_faults | on_rise;
	assign cfg_hit    = (cmd_code == `OVR_CFG_CODE);
	assign resp       = cfg_q[`OVR_RESP_HI:`OVR_RESP_LO];
	assign retries    = cfg_q[`OVR_RETRY_HI:`OVR_RETRY_LO];
	assign delay_exp  = cfg_q[`OVR_DELAY_HI:`OVR_DELAY_LO];
	assign tmr_cancel = any_clear | off_cmd | other_fault;
	assign may_retry  = (retries == `OVR_RETRY_FOREVER) | (attempt_count < retries);

	delay_timer #(
		.UNIT_W(UNIT_W)
	) u_timer (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.start      (tmr_start_q),
		.cancel     (tmr_cancel),
		.exponent   (delay_exp),
		.unit_cycles(unit_cycles),
		.busy       (tmr_busy),
		.done       (tmr_done)
	);

	// Two-stage synchronisers, one per pin
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			reg [1:0] stage_q;
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					stage_q <= 2'h0;
				end else begin
					stage_q <= {stage_q[0], pin_async[gi]};
				end
			end
			assign pin_sync[gi] = stage_q[1];
		end
	endgenerate

	// Commanded-on history for the off-then-on clear
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			on_prev_q <= 1'b0;
		end else begin
			on_prev_q <= on_now;
		end
	end

	// Configuration byte
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= `OVR_CFG_RESET;
		end else if (wr_byte && cfg_hit) begin
			cfg_q <= wr_data;
		end
	end

	// Read port
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_byte;
			if (rd_byte) begin
				rd_data <= cfg_hit ? cfg_q : 8'h00;
			end
		end
	end

	// Response state machine
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q       <= ST_RUN;
			output_enable <= 1'b0;
			fault_latched <= 1'b0;
			restart_pulse <= 1'b0;
			attempt_count <= 3'h0;
			tmr_start_q   <= 1'b0;
		end else begin
			tmr_start_q   <= 1'b0;
			restart_pulse <= 1'b0;
			if (any_clear || !on_now) begin
				state_q       <= ST_RUN;
				output_enable <= on_now;
				fault_latched <= 1'b0;
				attempt_count <= 3'h0;
			end else if (other_fault) begin
				state_q       <= ST_LATCHED;
				output_enable <= 1'b0;
			end else begin
				case (state_q)
				ST_RUN: begin
					output_enable <= 1'b1;
					if (fault) begin
						case (resp)
						`OVR_RESP_IGNORE: begin
							state_q <= ST_RUN;
						end
						`OVR_RESP_DELAYED: begin
							state_q     <= ST_DELAY;
							tmr_start_q <= 1'b1;
						end
						`OVR_RESP_SHUTDOWN: begin
							output_enable <= 1'b0;
							fault_latched <= 1'b1;
							state_q       <= may_retry ? ST_WAIT : ST_LATCHED;
							tmr_start_q   <= may_retry;
						end
						default: begin
							output_enable <= 1'b0;
							state_q       <= ST_HOLD;
						end
						endcase
					end
				end
				ST_DELAY: begin
					if (!fault && !tmr_busy && !tmr_start_q) begin
						state_q <= ST_RUN;
					end else if (tmr_done && fault) begin
						output_enable <= 1'b0;
						fault_latched <= 1'b1;
						state_q       <= may_retry ? ST_WAIT : ST_LATCHED;
						tmr_start_q   <= may_retry;
					end else if (tmr_done) begin
						state_q <= ST_RUN;
					end
				end
				ST_WAIT: begin
					output_enable <= 1'b0;
					if (tmr_done) begin
						restart_pulse <= 1'b1;
						output_enable <= 1'b1;
						if (attempt_count != 3'h7) begin
							attempt_count <= attempt_count + 3'h1;
						end
						state_q <= ST_RUN;
					end
				end
				ST_HOLD: begin
					output_enable <= ~fault;
					if (!fault) begin
						state_q <= ST_RUN;
					end
				end
				ST_LATCHED: begin
					output_enable <= 1'b0;
					fault_latched <= 1'b1;
				end
				default: begin
					state_q <= ST_RUN;
				end
				endcase
			end
		end
	end
endmodule // ov_fault_response

// >>> verification/ov_host_model.sv
// Purpose: Byte-bus host for the fault response block
// Assumes: Request taken on one rising edge
// Notes: Idle code and data lines show the inverse value; strobes idle low
`timescale 1ns/100ps
module ov_host_model (
	// Clock
	input  logic       clk_sys,
	// Byte bus
	output logic [7:0] cmd_code = 8'h00,
	output logic       wr_byte = 1'b0,
	output logic [7:0] wr_data = 8'h00,
	output logic       rd_byte = 1'b0
);
	task xfer(input logic w, input logic [7:0] c, d);
		@(posedge clk_sys);
		#1;
		cmd_code = c;
		wr_data = d;
		wr_byte = w;
		rd_byte = !w;
		@(posedge clk_sys);
		#1;
		wr_byte = 0;
		rd_byte = 0;
		cmd_code = ~c;
		wr_data = ~d;
	endtask
endmodule // ov_host_model

// >>> verification/ov_fault_response_asserts.sv
// Purpose: Port checks for the fault response block
// Assumes: One clock, async low reset
// Notes: Bound from the bench top
`timescale 1ns/100ps
module ov_fault_response_asserts (
	// Clock and reset
	input logic       clk_sys,
	input logic       rst_n,
	// Bus
	input logic       rd_byte,
	input logic       rd_valid,
	input logic [7:0] rd_data,
	// Converter
	input logic       clear_faults,
	input logic       output_on_async,
	input logic       output_enable,
	input logic       fault_latched,
	input logic       restart_pulse,
	input logic [2:0] attempt_count
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence off_held;
		!output_on_async [*6];
	endsequence
	a_rd_answer: assert property (rd_byte |=> rd_valid)
		else $error("read not answered");
	a_rd_hold: assert property (!rd_valid |-> $stable(rd_data))
		else $error("read data moved");
	a_restart_once: assert property (restart_pulse |=> !restart_pulse)
		else $error("restart pulse too long");
	a_restart_on: assert property (restart_pulse |-> output_enable)
		else $error("restart without enable");
	a_attempt_step: assert property (restart_pulse && $past(attempt_count) != 3'h7
		|-> attempt_count == $past(attempt_count) + 3'h1) else $error("attempt count off");
	a_clear_zero: assert property (clear_faults |=> attempt_count == 3'h0 && !fault_latched)
		else $error("clear ignored");
	a_off_stops: assert property (off_held |-> !output_enable && attempt_count == 3'h0)
		else $error("output on while commanded off");
	a_latch_off: assert property ($rose(fault_latched) |-> !output_enable)
		else $error("latched with output on");
endmodule // ov_fault_response_asserts

// >>> verification/ov_fault_response_tb_top.sv
// Purpose: Self-checking bench for the fault response block
// Assumes: Delay unit of one or two cycles
// Notes: Reads queued, checked on rd_valid
`timescale 1ns/100ps
module ov_fault_response_tb_top;
	logic       clk_sys = 0, rst_n = 0, clear_status = 0, clear_faults = 0;
	logic       ov_fault_async = 0, output_on_async = 1, other_fault = 0, rd_byte, wr_byte, rd_valid;
	logic [15:0] unit_cycles = 16'h0001;
	logic       output_enable, fault_latched, restart_pulse;
	logic [7:0] cmd_code, wr_data, rd_data, c;
	logic [2:0] attempt_count;
	logic [7:0] exp_q[$];
	int         n_fail = 0, samples_checked = 0, r;
	always #4 clk_sys = ~clk_sys;
	ov_host_model host (.clk_sys(clk_sys), .cmd_code(cmd_code), .wr_byte(wr_byte),
		.wr_data(wr_data), .rd_byte(rd_byte));
	ov_fault_response DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_code(cmd_code),
		.wr_byte(wr_byte), .wr_data(wr_data), .rd_byte(rd_byte), .rd_data(rd_data),
		.rd_valid(rd_valid), .unit_cycles(unit_cycles), .clear_status(clear_status),
		.clear_faults(clear_faults), .ov_fault_async(ov_fault_async),
		.output_on_async(output_on_async), .other_fault(other_fault), .output_enable(output_enable),
		.fault_latched(fault_latched), .restart_pulse(restart_pulse), .attempt_count(attempt_count));
	task cmp(input logic [7:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cmp_st(input logic [4:0] e);
		cmp({3'h0, fault_latched, output_enable, attempt_count}, {3'h0, e});
	endtask
	task rd(input logic [7:0] cc, e);
		exp_q.push_back(e);
		host.xfer(0, cc, 8'h00);
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task fault(input logic [7:0] cfg, input int n);
		host.xfer(1, 8'h41, cfg);
		ov_fault_async = 1;
		tick(n);
	endtask
	task release_clear(input logic s);
		ov_fault_async = 0;
		tick(3);
		clear_status = s;
		clear_faults = !s;
		tick(1);
		clear_status = 0;
		clear_faults = 0;
		tick(20);
	endtask
	task report_and_stop;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys) if (rd_valid === 1'b1) cmp(rd_data, exp_q.pop_front());
	initial begin
		#60000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		void'($urandom(63640));
		tick(10);
		rst_n = 1;
		rd(8'h41, 8'h80);
		host.xfer(1, 8'h40, 8'h55);
		rd(8'h41, 8'h80);
		rd(8'h42, 8'h00);
		c = $urandom;
		host.xfer(1, 8'h41, c);
		rd(8'h41, c);
		for (r = 0; r < 7; r++) begin
			fault({2'b10, r[2:0], 3'b000}, 100);
			cmp_st({2'b10, r[2:0]});
			release_clear(r[0]);
			cmp_st(5'h08);
		end
		fault(8'hb8, 200);
		cmp({5'h00, attempt_count}, 8'h07);
		other_fault = 1;
		tick(5);
		cmp_st(5'h17);
		other_fault = 0;
		tick(20);
		cmp_st(5'h17);
		output_on_async = 0;
		tick(10);
		cmp_st(5'h00);
		output_on_async = 1;
		release_clear(0);
		fault(8'h00, 100);
		cmp_st(5'h08);
		release_clear(0);
		fault(8'hc0, 50);
		cmp_st(5'h00);
		ov_fault_async = 0;
		tick(20);
		cmp_st(5'h08);
		unit_cycles = 16'h0002;
		fault(8'h4f, 100);
		cmp_st(5'h08);
		tick(300);
		cmp_st(5'h10);
		tick(500);
		cmp_st(5'h11);
		ov_fault_async = 0;
		rst_n = 0;
		tick(2);
		rst_n = 1;
		tick(5);
		cmp_st(5'h08);
		rd(8'h41, 8'h80);
		release_clear(1);
		report_and_stop();
	end
endmodule // ov_fault_response_tb_top
bind ov_fault_response ov_fault_response_asserts chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.rd_byte(rd_byte), .rd_valid(rd_valid), .rd_data(rd_data), .clear_faults(clear_faults),
	.output_on_async(output_on_async), .output_enable(output_enable),
	.fault_latched(fault_latched), .restart_pulse(restart_pulse), .attempt_count(attempt_count));
